// ===== hw/tgen_pkg.sv
// Purpose: Shared constants and carriers for the test traffic generator
// Assumes: One user clock, 64-bit data per lane
// Notes:   Nothing here is imported; users write tgen_pkg::name
package tgen_pkg;

    // ------------------------------------------------------------
    // Widths and seeds
    // ------------------------------------------------------------
    localparam int          LANE_BITS     = 64;
    localparam int          CNT_W         = 8;
    localparam logic [15:0] LFSR_SEED     = 16'hABE0;
    localparam logic [15:0] LFSR_TAPS     = 16'hB400;
    localparam logic [7:0]  FRAME_SIZE_0  = 8'h00;
    localparam logic [7:0]  CNT_ONE       = 8'h01;
    localparam int          DEB_STAGES    = 4;
    localparam int          FIFO_DEPTH    = 16;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       hard_err;
        logic       soft_err;
        logic       channel_up;
    } link_status_t;

    typedef struct packed {
        logic       frame_mismatch;
        logic       flow_msg_mismatch;
        logic       ctrl_blk_mismatch;
    } check_event_t;

endpackage : tgen_pkg

// ===== hw/tgen_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, depth a power of two
// Notes:   Read data comes from a register; ready on fill side is honest full
`timescale 1ns/1ps
module tgen_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;
    logic             empty;

    assign empty    = (wr_q == rd_q);
    // Output register counts as one slot beyond the array
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign pop      = !empty && (!out_valid || out_ready);
    assign push     = in_valid && in_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem_q[rd_q[AW-1:0]];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_q - rd_q) <= (AW+1)'(DEPTH))
        else $error("fifo fill beyond its depth");

endmodule : tgen_fifo

// ===== hw/tgen_top.sv
// Purpose: Framed pseudo-random traffic source for a link transmit stream
// Assumes: Link core and generator share clk; checker events arrive on clk
// Notes:   Beats are built ahead into a FIFO so the stream holds under stall
//
// Operation
// - LFSR payload sent after reset and channel ready
// - Two 8-bit counters make end-of-frame marker
// - Frame size grows by one per frame
// - Byte qualifier from low LFSR bits
// - Valid held, beat stable until accepted
// - Generator advances only with channel up and FIFO space
// - Varied lengths, including single-beat frames
// - Byte qualifier counts bytes in last beat
// - Payload is 64 bits per lane
// - Top reset debounced on user clock
// - Transceiver reset debounced on init clock
// - Link status outputs are registered
// - One lane-ready output per transceiver
// - 8-bit count of frame data mismatches
// - Flag on flow-message word mismatch
// - Flag on control-block word mismatch
// - Transmit side held idle in receive-only builds
`timescale 1ns/1ps
module tgen_top #(
    parameter int  LANES   = 1,
    parameter bit  TX_ON   = 1'b1,
    parameter int  DEPTH   = tgen_pkg::FIFO_DEPTH
) (
    input  wire logic                                clk,
    input  wire logic                                rst_b,
    input  wire logic                                reset_pin,
    input  wire logic                                init_clk_tick,
    input  wire logic                                xcvr_reset_pin,
    output logic                                     xcvr_reset,
    input  wire tgen_pkg::link_status_t              link_status,
    input  wire logic [LANES-1:0]                    lane_up_in,
    output tgen_pkg::link_status_t                   status_q,
    output logic      [LANES-1:0]                    lane_up_q,
    input  wire tgen_pkg::check_event_t              check_event,
    output logic      [tgen_pkg::CNT_W-1:0]          data_err_count,
    output logic                                     flow_msg_err,
    output logic                                     ctrl_blk_err,
    output logic      [tgen_pkg::LANE_BITS*LANES-1:0] tx_tdata,
    output logic      [LANES*8-1:0]                  tx_tkeep,
    output logic                                     tx_tlast,
    output logic                                     tx_tvalid,
    input  wire logic                                tx_tready
);
    localparam int DW    = tgen_pkg::LANE_BITS * LANES;
    localparam int KW    = LANES * 8;
    localparam int BW    = DW + KW + 1;
    localparam int CW    = tgen_pkg::CNT_W;

    // ------------------------------------------------------------
    // Reset debouncers
    // ------------------------------------------------------------
    logic [tgen_pkg::DEB_STAGES-1:0] rst_sh_q;
    logic                            gen_reset_q;
    logic [tgen_pkg::DEB_STAGES-1:0] xr_sh_q;

    // Pin passes four flops; debounce wants the upper three stages in agreement
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sh_q    <= '1;
            gen_reset_q <= 1'b1;
        end else begin
            rst_sh_q    <= {rst_sh_q[tgen_pkg::DEB_STAGES-2:0], reset_pin};
            if (&rst_sh_q[tgen_pkg::DEB_STAGES-1:1]) begin
                gen_reset_q <= 1'b1;
            end else if (~|rst_sh_q[tgen_pkg::DEB_STAGES-1:1]) begin
                gen_reset_q <= 1'b0;
            end
        end
    end

    // Init clock reaches us as an enable from a slower divider
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            xr_sh_q    <= '1;
            xcvr_reset <= 1'b1;
        end else if (init_clk_tick) begin
            xr_sh_q <= {xr_sh_q[tgen_pkg::DEB_STAGES-2:0], xcvr_reset_pin};
            if (&xr_sh_q[tgen_pkg::DEB_STAGES-1:1]) begin
                xcvr_reset <= 1'b1;
            end else if (~|xr_sh_q[tgen_pkg::DEB_STAGES-1:1]) begin
                xcvr_reset <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Registered status and checker reports
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q  <= '0;
            lane_up_q <= '0;
        end else begin
            status_q  <= link_status;
            lane_up_q <= lane_up_in;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_err_count <= '0;
            flow_msg_err   <= 1'b0;
            ctrl_blk_err   <= 1'b0;
        end else if (gen_reset_q) begin
            data_err_count <= '0;
            flow_msg_err   <= 1'b0;
            ctrl_blk_err   <= 1'b0;
        end else begin
            // Saturate so a broken link does not wrap back to a clean count
            if (check_event.frame_mismatch && !(&data_err_count)) begin
                data_err_count <= data_err_count + tgen_pkg::CNT_ONE;
            end
            if (check_event.flow_msg_mismatch) begin
                flow_msg_err <= 1'b1;
            end
            if (check_event.ctrl_blk_mismatch) begin
                ctrl_blk_err <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Beat builder
    // ------------------------------------------------------------
    logic [15:0]   lfsr_q;
    logic [CW-1:0] frame_size_q;
    logic [CW-1:0] sent_q;
    logic          run;
    logic          build;
    logic          fifo_in_ready;
    logic          last_beat;
    logic [KW-1:0] keep;
    logic [DW-1:0] payload;

    // Channel ready is the permission to send
    assign run       = TX_ON && !gen_reset_q && status_q.channel_up;
    // Builder only advances when the FIFO can take the beat
    assign build     = run && fifo_in_ready;
    // Frame ends once sent count reaches size; size 0 gives a one-beat frame
    assign last_beat = (sent_q >= frame_size_q);

    always_comb begin
        keep = '1;
        if (last_beat) begin
            // Low LFSR bits pick how many bytes the final beat holds
            keep = {KW{1'b1}} >> lfsr_q[2:0];
        end
    end

    always_comb begin
        payload = '0;
        for (int i = 0; i < DW / 16; i++) begin
            payload[i*16 +: 16] = lfsr_q ^ 16'(i);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lfsr_q <= tgen_pkg::LFSR_SEED;
        end else if (gen_reset_q) begin
            lfsr_q <= tgen_pkg::LFSR_SEED;
        end else if (build) begin
            // Steps once per beat that will be accepted, in order
            lfsr_q <= {lfsr_q[14:0], ^(lfsr_q & tgen_pkg::LFSR_TAPS)};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_size_q <= tgen_pkg::FRAME_SIZE_0;
            sent_q       <= '0;
        end else if (gen_reset_q) begin
            frame_size_q <= tgen_pkg::FRAME_SIZE_0;
            sent_q       <= '0;
        end else if (build) begin
            if (last_beat) begin
                frame_size_q <= frame_size_q + tgen_pkg::CNT_ONE;
                sent_q       <= '0;
            end else begin
                sent_q <= sent_q + tgen_pkg::CNT_ONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Beat FIFO to the link
    // ------------------------------------------------------------
    logic [BW-1:0] beat_out;

    // Registered FIFO output keeps beat stable while valid waits
    tgen_fifo #(
        .WIDTH (BW),
        .DEPTH (DEPTH)
    ) beat_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (run),
        .in_ready  (fifo_in_ready),
        .in_data   ({last_beat, keep, payload}),
        .out_valid (tx_tvalid),
        .out_ready (tx_tready),
        .out_data  (beat_out)
    );

    assign tx_tlast = beat_out[BW-1];
    assign tx_tkeep = beat_out[DW +: KW];
    assign tx_tdata = beat_out[DW-1:0];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_beat_held_stable: assert property (@(posedge clk) disable iff (!rst_b)
        tx_tvalid && !tx_tready |=> tx_tvalid && $stable(beat_out))
        else $error("beat changed before acceptance");

    a_no_send_down: assert property (@(posedge clk) disable iff (!rst_b)
        !run && !gen_reset_q |=> $stable(lfsr_q) && $stable(sent_q) && $stable(frame_size_q))
        else $error("generator moved while channel down");

    a_rx_only_idle: assert property (@(posedge clk) disable iff (!rst_b)
        !TX_ON |-> !tx_tvalid)
        else $error("receive-only build sent a beat");

    a_size_grows: assert property (@(posedge clk) disable iff (!rst_b)
        build && last_beat && !gen_reset_q
        |=> frame_size_q == $past(frame_size_q) + tgen_pkg::CNT_ONE)
        else $error("frame size did not grow");

    a_sent_counts: assert property (@(posedge clk) disable iff (!rst_b)
        build && !last_beat |=> sent_q == $past(sent_q) + tgen_pkg::CNT_ONE)
        else $error("sent count did not advance");

    a_sent_clears: assert property (@(posedge clk) disable iff (!rst_b)
        build && last_beat && !gen_reset_q |=> sent_q == '0)
        else $error("sent count not cleared");

    a_lfsr_holds: assert property (@(posedge clk) disable iff (!rst_b)
        !build && !gen_reset_q |=> $stable(lfsr_q))
        else $error("lfsr stepped without a beat");

    // Checked at the pins so a corrupted FIFO word is caught too
    a_keep_full_mid: assert property (@(posedge clk) disable iff (!rst_b)
        tx_tvalid && !tx_tlast |-> tx_tkeep == {KW{1'b1}})
        else $error("partial keep before frame end");

    a_keep_first_byte: assert property (@(posedge clk) disable iff (!rst_b)
        tx_tvalid |-> tx_tkeep[0])
        else $error("beat without its first byte");

    a_status_reg: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 status_q == $past(link_status) && lane_up_q == $past(lane_up_in))
        else $error("status not registered");

    a_reset_deb_high: assert property (@(posedge clk) disable iff (!rst_b)
        &rst_sh_q[tgen_pkg::DEB_STAGES-1:1] |=> gen_reset_q)
        else $error("settled reset pin not applied");

    a_reset_deb_low: assert property (@(posedge clk) disable iff (!rst_b)
        ~|rst_sh_q[tgen_pkg::DEB_STAGES-1:1] |=> !gen_reset_q)
        else $error("settled reset pin not released");

    a_xcvr_deb_high: assert property (@(posedge clk) disable iff (!rst_b)
        init_clk_tick && &xr_sh_q[tgen_pkg::DEB_STAGES-1:1] |=> xcvr_reset)
        else $error("transceiver reset not applied");

    a_xcvr_deb_low: assert property (@(posedge clk) disable iff (!rst_b)
        init_clk_tick && ~|xr_sh_q[tgen_pkg::DEB_STAGES-1:1] |=> !xcvr_reset)
        else $error("transceiver reset not released");

    a_gen_reset_clears: assert property (@(posedge clk) disable iff (!rst_b)
        gen_reset_q |=> data_err_count == '0 && !flow_msg_err && !ctrl_blk_err)
        else $error("reports kept through reset");

    a_err_count_step: assert property (@(posedge clk) disable iff (!rst_b)
        check_event.frame_mismatch && !gen_reset_q && !(&data_err_count)
        |=> data_err_count == $past(data_err_count) + tgen_pkg::CNT_ONE)
        else $error("mismatch not counted");

    a_err_count_sat: assert property (@(posedge clk) disable iff (!rst_b)
        (&data_err_count) && !gen_reset_q |=> &data_err_count)
        else $error("mismatch count wrapped");

    a_err_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
        check_event.flow_msg_mismatch && !gen_reset_q |=> flow_msg_err)
        else $error("flow message error not flagged");

    a_ctrl_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
        check_event.ctrl_blk_mismatch && !gen_reset_q |=> ctrl_blk_err)
        else $error("control block error not flagged");

    c_single_beat: cover property (@(posedge clk) disable iff (!rst_b)
        !tx_tvalid ##1 tx_tvalid && tx_tready && tx_tlast);
    c_stall: cover property (@(posedge clk) disable iff (!rst_b)
        tx_tvalid && !tx_tready [*2]);
    c_fifo_full: cover property (@(posedge clk) disable iff (!rst_b)
        run && !fifo_in_ready);
    c_partial_end: cover property (@(posedge clk) disable iff (!rst_b)
        tx_tvalid && tx_tlast && tx_tkeep != {KW{1'b1}});
    c_full_end: cover property (@(posedge clk) disable iff (!rst_b)
        tx_tvalid && tx_tready && tx_tlast && (&tx_tkeep));

endmodule : tgen_top

// ===== tb/link_sink.sv
// Purpose: Far-side model of the link transmit stream sink
// Assumes: Shares clk with the generator
// Notes:   Slow mode stalls two cycles of three to stress holding
`timescale 1ns/1ps
module link_sink (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic slow,
    input  wire logic tvalid,
    output logic      tready
);
    // ------------------------------------------------------------
    // Ready pattern
    // ------------------------------------------------------------
    logic [1:0] ph_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_q   <= 2'h0;
            tready <= 1'b0;
        end else begin
            // Phase moves only while a beat is offered, so stalls land on real beats
            if (tvalid) begin
                ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
            end
            // Beat counts as taken only where tvalid meets tready
            tready <= !slow || (ph_q == 2'h1);
        end
    end
endmodule : link_sink

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the traffic generator top
// Assumes: Two lanes; sink model stands in for the link core
// Notes:   Expected stream rebuilt from seed and taps
`timescale 1ns/1ps
module testbench;
    logic                   clk, rst_b, reset_pin, tick, xpin, xcvr_reset, slow;
    tgen_pkg::link_status_t link_status, status_q;
    tgen_pkg::check_event_t ev;
    logic [1:0]             lane_in, lane_q;
    logic [7:0]             err_cnt;
    logic                   flow_err, ctrl_err, tlast, tvalid, tready, pend;
    logic [127:0]           tdata, exp_d, held;
    logic [15:0]            tkeep;
    logic [15:0]            lfsr = tgen_pkg::LFSR_SEED;
    logic                   ro_tvalid;
    logic                   ro_seen = 1'b0;
    int                     n_errors = 0, checks_done = 0, beat_n = 0, frame_sz = 0, n_frames = 0;
    int                     tick_n = 0;

    tgen_top #(.LANES(2)) u_dut (.clk(clk), .rst_b(rst_b), .reset_pin(reset_pin),
        .init_clk_tick(tick), .xcvr_reset_pin(xpin), .xcvr_reset(xcvr_reset),
        .link_status(link_status), .lane_up_in(lane_in), .status_q(status_q),
        .lane_up_q(lane_q), .check_event(ev), .data_err_count(err_cnt),
        .flow_msg_err(flow_err), .ctrl_blk_err(ctrl_err), .tx_tdata(tdata),
        .tx_tkeep(tkeep), .tx_tlast(tlast), .tx_tvalid(tvalid), .tx_tready(tready));
    link_sink u_sink (.clk(clk), .rst_b(rst_b), .slow(slow), .tvalid(tvalid),
        .tready(tready));
    // Receive-only build shares every input except tx_tready (tied high) and lane_up_in (lane 0 only) but must never offer a beat
    tgen_top #(.LANES(1), .TX_ON(1'b0)) u_rx_only (.clk(clk), .rst_b(rst_b),
        .reset_pin(reset_pin), .init_clk_tick(tick), .xcvr_reset_pin(xpin),
        .xcvr_reset(), .link_status(link_status), .lane_up_in(lane_in[0]), .status_q(),
        .lane_up_q(), .check_event(ev), .data_err_count(), .flow_msg_err(),
        .ctrl_blk_err(), .tx_tdata(), .tx_tkeep(), .tx_tlast(), .tx_tvalid(ro_tvalid),
        .tx_tready(1'b1));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic pulse(input tgen_pkg::check_event_t e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= '0;
    endtask : pulse
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Clock, slow init tick, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Init rate is a slower enable, taken from the link clock as one cycle in four
    always @(posedge clk) begin
        tick_n <= tick_n + 1;
        tick   <= (tick_n % 4 == 0);
    end
    initial begin
        #200000;
        n_errors++;
        results();
    end

    // ------------------------------------------------------------
    // Stream monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst_b && pend) begin
            check({tvalid, tdata}, {1'b1, held});
        end
        pend = (tvalid === 1'b1) && (tready !== 1'b1);
        held = tdata;
        if (ro_tvalid !== 1'b0) ro_seen = 1'b1;
        if (rst_b && tvalid === 1'b1 && tready === 1'b1) begin
            for (int i = 0; i < 8; i++) exp_d[16*i +: 16] = lfsr ^ i[15:0];
            check(tdata, exp_d);
            check(tlast, beat_n == frame_sz);
            if (tlast === 1'b1) check(tkeep, 16'hFFFF >> lfsr[2:0]);
            lfsr = {lfsr[14:0], ^(lfsr & tgen_pkg::LFSR_TAPS)};
            beat_n++;
            if (tlast === 1'b1) begin
                beat_n = 0;
                frame_sz++;
                n_frames++;
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] st;
        logic [1:0] lane;
    } row_t;
    row_t rows [4] = '{'{3'h5, 2'h1}, '{3'h2, 2'h2}, '{3'h7, 2'h3}, '{3'h0, 2'h0}};

    initial begin
        {rst_b, xpin, slow, lane_in} = '0;
        reset_pin = 1'b1;
        link_status = '0;
        ev = '0;
        cyc(4);
        check({status_q, err_cnt, flow_err, ctrl_err, tvalid, xcvr_reset}, 8'h01);
        rst_b <= 1'b1;
        foreach (rows[k]) begin
            @(posedge clk);
            {link_status, lane_in} <= rows[k];
            cyc(1);
            #1 check({status_q, lane_q}, rows[k]);
        end
        $display("test status done");
        pulse(3'h4);
        cyc(3);
        check(err_cnt, 8'h00);
        reset_pin <= 1'b0;
        cyc(20);
        check(tvalid, 1'b0);
        repeat (3) pulse(3'h4);
        pulse(3'h2);
        cyc(3);
        check({err_cnt, flow_err, ctrl_err}, {8'h03, 2'b10});
        pulse(3'h1);
        cyc(3);
        check({flow_err, ctrl_err}, 2'b11);
        repeat (300) pulse(3'h4);
        cyc(3);
        check(err_cnt, 8'hFF);
        $display("test checker done");
        cyc(60);
        check(xcvr_reset, 1'b0);
        xpin <= 1'b1;
        cyc(60);
        check(xcvr_reset, 1'b1);
        xpin <= 1'b0;
        $display("test transceiver reset done");
        @(posedge clk);
        link_status <= 3'h1;
        for (int w = 0; w < 2000 && n_frames < 8; w++) @(posedge clk);
        slow <= 1'b1;
        for (int w = 0; w < 8000 && n_frames < 16; w++) @(posedge clk);
        check(n_frames >= 16, 1'b1);
        check(ro_seen, 1'b0);
        $display("test stream done");
        results();
    end
endmodule : testbench
